// ### clk_chk.sv
// Assertion checker for the CPU clock source controller
`default_nettype none
module clk_chk
  import clk_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Requests
  input wire logic wr_en,
  input wire logic wr_bit,
  input wire logic [2:0] wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic halt_exec,
  input wire logic stop_exec,
  // Observed state
  input wire logic [7:0] osc_mode_select_reg,
  input wire logic [7:0] internal_osc_mode_reg,
  input wire logic [7:0] main_clock_mode_reg,
  input wire logic cpu_on_subsystem_flag,
  input wire logic cpu_on_highspeed_flag,
  input wire logic [1:0] cpu_src,
  input wire logic internal_osc_run,
  input wire logic halt_mode,
  input wire logic stop_mode,
  input wire logic sub_port_in_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Last select value and a saturating count of its changes
  logic [2:0] hs_r;
  logic [2:0] hs_nxt;
  always_comb
  begin
    hs_nxt = hs_r;
    hs_nxt[2] = main_clock_mode_reg[HS_SRC_BIT];
    if (hs_nxt[2] != hs_r[2] && hs_r[1:0] != 2'h3)
      hs_nxt[1:0] = hs_r[1:0] + 2'h1;
  end
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      hs_r <= 3'h0;
    else
      hs_r <= hs_nxt;
  sequence s_run;
    !halt_mode && !stop_mode;
  endsequence
  sequence s_byte_wr;
    s_run ##0 wr_en && !wr_bit && wr_sel == SEL_OSC_MODE;
  endsequence
  property p_mode_byte;
    s_byte_wr |=> osc_mode_select_reg == $past(wr_data);
  endproperty
  a_mode_byte: assert property (p_mode_byte) else $error("mode byte write lost");
  property p_src_code;
    cpu_src == (cpu_on_subsystem_flag ? 2'h2 : {1'b0, cpu_on_highspeed_flag});
  endproperty
  a_src_code: assert property (p_src_code) else $error("source code wrong");
  property p_int_stop;
    internal_osc_mode_reg[INT_STOP_BIT] |-> !internal_osc_run;
  endproperty
  a_int_stop: assert property (p_int_stop) else $error("internal osc still runs");
  property p_stop;
    s_run ##0 stop_exec |=> stop_mode && !internal_osc_run;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not entered");
  property p_halt;
    s_run ##0 halt_exec && !stop_exec |=> halt_mode && !stop_mode;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not entered");
  property p_hs_once;
    hs_r[1:0] <= 2'h1;
  endproperty
  a_hs_once: assert property (p_hs_once) else $error("source select changed twice");
  property p_port_mode;
    sub_port_in_mode == !osc_mode_select_reg[OSC_MODE_BIT];
  endproperty
  a_port_mode: assert property (p_port_mode) else $error("pin mode wrong");
  property p_reset_src;
    !$past(rst_b) |-> cpu_src == 2'h0 && osc_mode_select_reg == OSC_MODE_RESET;
  endproperty
  a_reset_src: assert property (p_reset_src) else $error("reset state wrong");
endmodule // clk_chk
bind cpu_clock_source_control clk_chk clk_chk_i (.core_clk, .rst_b, .wr_en, .wr_bit, .wr_sel, .wr_data,
  .halt_exec, .stop_exec, .osc_mode_select_reg, .internal_osc_mode_reg, .main_clock_mode_reg,
  .cpu_on_subsystem_flag, .cpu_on_highspeed_flag, .cpu_src, .internal_osc_run, .halt_mode, .stop_mode,
  .sub_port_in_mode);
`default_nettype wire

// ### clk_ctrl_pkg.sv
// Constants for the CPU clock source controller
`default_nettype none
package clk_ctrl_pkg;
  // Register reset values
  localparam logic [7:0] OSC_MODE_RESET = 8'h00;
  localparam logic [7:0] MAIN_OSC_RESET = 8'h80;
  localparam logic [7:0] MAIN_CLK_RESET = 8'h00;
  localparam logic [7:0] CPU_CTRL_RESET = 8'h00;
  localparam logic [7:0] INT_OSC_RESET = 8'h00;
  localparam logic [7:0] STAB_SEL_RESET = 8'h05;
  // Field positions
  localparam int EXT_CLK_BIT = 7;
  localparam int OSC_MODE_BIT = 6;
  localparam int MAIN_STOP_BIT = 7;
  localparam int HS_SRC_BIT = 2;
  localparam int MAIN_MODE_BIT = 0;
  localparam int CPU_SUB_BIT = 4;
  localparam int INT_STOP_BIT = 0;
  localparam int STAB_SEL_W = 3;
  // Register selects on the write port
  localparam logic [2:0] SEL_OSC_MODE = 3'h0;
  localparam logic [2:0] SEL_CPU_CTRL = 3'h1;
  localparam logic [2:0] SEL_INT_OSC = 3'h2;
  localparam logic [2:0] SEL_MAIN_OSC = 3'h3;
  localparam logic [2:0] SEL_MAIN_CLK = 3'h4;
  localparam logic [2:0] SEL_STAB_SEL = 3'h5;
  // Stabilization wait, in core_clk cycles, per select code
  // Wide enough for the base wait shifted by the largest select code
  localparam int STAB_CNT_W = 19;
  localparam logic [STAB_CNT_W-1:0] STAB_BASE_CYCLES = 19'h00800;
  typedef enum logic [1:0] {SRC_INTERNAL, SRC_HIGHSPEED, SRC_SUBSYSTEM} cpu_src_e;
  typedef enum logic [1:0] {PM_RUN, PM_HALT, PM_STOP, PM_WAKE} power_mode_e;
endpackage : clk_ctrl_pkg
`default_nettype wire

// ### cpu_clock_source_control.sv
// CPU clock source selection, oscillator stop and standby control
`default_nettype none
// Overview of operation
// - Mode select register takes bit or byte writes; reset clears it to zero.
// - Source flags: 00 internal, 01 high-speed, 1x subsystem.
// - Writing one to internal stop bit halts the internal oscillator.
// - STOP instruction enters STOP standby and halts internal oscillator.
// - High-speed source select changes only once after each reset release.
// - HALT instruction enters HALT standby from any of three sources.
// - Subsystem crystal pins default to input port mode after reset.
// - External clock and oscillator mode selects at bits 7 and 6.
// - Main oscillator stop control at bit 7 of its register.
// - High-speed select bit 2, main mode bit 0; CPU subsystem bit 4.
module cpu_clock_source_control
  import clk_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register write port
  input wire logic wr_en,
  input wire logic wr_bit,
  input wire logic [2:0] wr_sel,
  input wire logic [2:0] wr_bit_pos,
  input wire logic [7:0] wr_data,
  // Instruction strobes from the CPU core
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire logic wake_req,
  // Oscillator pins seen as levels
  input wire logic sub_crystal_in_pin,
  input wire logic sub_crystal_out_pin,
  // Register contents
  output logic [7:0] osc_mode_select_reg,
  output logic [7:0] cpu_clock_ctrl_reg,
  output logic [7:0] internal_osc_mode_reg,
  output logic [7:0] main_osc_ctrl_reg,
  output logic [7:0] main_clock_mode_reg,
  output logic [STAB_SEL_W-1:0] stabilization_time_select,
  output logic [7:0] stabilization_counter_status,
  // Status
  output logic cpu_on_subsystem_flag,
  output logic cpu_on_highspeed_flag,
  output logic [1:0] cpu_src,
  output logic internal_osc_run,
  output logic main_osc_run,
  output logic halt_mode,
  output logic stop_mode,
  // Subsystem pins as input port
  output logic sub_port_in_mode,
  output logic [1:0] sub_port_data
);
  stab_if st ();
  stab_counter u_stab (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .st(st)
  );

  logic [7:0] osc_r, osc_nxt, pcc_r, pcc_nxt, rcm_r, rcm_nxt;
  logic [7:0] moc_r, moc_nxt, mcm_r, mcm_nxt;
  logic [STAB_SEL_W-1:0] stabilization_time_select_r, stabilization_time_select_nxt;
  logic highspeed_source_select_locked_r, highspeed_source_select_locked_nxt;
  logic cls_r, cls_nxt, mcs_r, mcs_nxt;
  logic start_r, start_nxt;
  power_mode_e pm_r, pm_nxt;
  logic [1:0] pin_meta_r, pin_sync_r;

  // Bit writes touch one position only, byte writes the whole register
  function automatic logic [7:0] merge(input logic [7:0] old);
    logic [7:0] res;
    res = old;
    if (wr_bit)
      res[wr_bit_pos] = wr_data[wr_bit_pos];
    else
      res = wr_data;
    return res;
  endfunction

  always_comb
  begin
    osc_nxt = osc_r;
    pcc_nxt = pcc_r;
    rcm_nxt = rcm_r;
    moc_nxt = moc_r;
    mcm_nxt = mcm_r;
    stabilization_time_select_nxt = stabilization_time_select_r;
    highspeed_source_select_locked_nxt = highspeed_source_select_locked_r;
    start_nxt = 1'b0;
    if (wr_en && pm_r == PM_RUN)
    begin
      unique case (wr_sel)
        SEL_OSC_MODE: osc_nxt = merge(osc_r);
        SEL_CPU_CTRL: pcc_nxt = merge(pcc_r);
        SEL_INT_OSC: rcm_nxt = merge(rcm_r);
        SEL_MAIN_OSC:
        begin
          moc_nxt = merge(moc_r);
          // Restart the wait when the main oscillator is released
          start_nxt = moc_r[MAIN_STOP_BIT] & ~moc_nxt[MAIN_STOP_BIT];
        end
        SEL_MAIN_CLK:
        begin
          mcm_nxt = merge(mcm_r);
          // One change allowed per reset; later writes keep the bit
          if (highspeed_source_select_locked_r)
            mcm_nxt[HS_SRC_BIT] = mcm_r[HS_SRC_BIT];
          else if (mcm_nxt[HS_SRC_BIT] != mcm_r[HS_SRC_BIT])
            highspeed_source_select_locked_nxt = 1'b1;
        end
        SEL_STAB_SEL: stabilization_time_select_nxt = STAB_SEL_W'(merge({5'h00, stabilization_time_select_r}));
        default: ;
      endcase
    end
  end

  // Source flags follow the selects; switch to main once done is set, or at once on an external clock
  always_comb
  begin
    cls_nxt = pcc_r[CPU_SUB_BIT];
    mcs_nxt = mcs_r;
    if (!mcm_r[MAIN_MODE_BIT] || moc_r[MAIN_STOP_BIT])
      mcs_nxt = 1'b0;
    else if (osc_r[EXT_CLK_BIT] || st.done)
      mcs_nxt = 1'b1;
  end

  // Standby sequencing
  always_comb
  begin
    pm_nxt = pm_r;
    unique case (pm_r)
      PM_RUN:
        if (stop_exec)
          pm_nxt = PM_STOP;
        else if (halt_exec)
          pm_nxt = PM_HALT;
      PM_HALT:
        if (wake_req)
          pm_nxt = PM_RUN;
      PM_STOP:
        if (wake_req)
          pm_nxt = (mcs_r && !osc_r[EXT_CLK_BIT]) ? PM_WAKE : PM_RUN;
      PM_WAKE:
        // Done is stale in the cycle the restart is issued
        if (st.done && !start_r)
          pm_nxt = PM_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      osc_r <= OSC_MODE_RESET;
      pcc_r <= CPU_CTRL_RESET;
      rcm_r <= INT_OSC_RESET;
      moc_r <= MAIN_OSC_RESET;
      mcm_r <= MAIN_CLK_RESET;
      stabilization_time_select_r <= STAB_SEL_RESET[STAB_SEL_W-1:0];
      highspeed_source_select_locked_r <= 1'b0;
      cls_r <= 1'b0;
      mcs_r <= 1'b0;
      start_r <= 1'b0;
      pm_r <= PM_RUN;
      pin_meta_r <= 2'b00;
      pin_sync_r <= 2'b00;
    end
    else
    begin
      osc_r <= osc_nxt;
      pcc_r <= pcc_nxt;
      rcm_r <= rcm_nxt;
      moc_r <= moc_nxt;
      mcm_r <= mcm_nxt;
      stabilization_time_select_r <= stabilization_time_select_nxt;
      highspeed_source_select_locked_r <= highspeed_source_select_locked_nxt;
      cls_r <= cls_nxt;
      mcs_r <= mcs_nxt;
      // Wake from STOP on crystal also restarts the wait
      start_r <= start_nxt | (pm_r == PM_STOP && pm_nxt == PM_WAKE);
      pm_r <= pm_nxt;
      pin_meta_r <= {sub_crystal_out_pin, sub_crystal_in_pin};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign st.start = start_r;
  assign st.sel = stabilization_time_select_r;

  assign osc_mode_select_reg = osc_r;
  assign cpu_clock_ctrl_reg = pcc_r;
  assign internal_osc_mode_reg = rcm_r;
  assign main_osc_ctrl_reg = moc_r;
  assign main_clock_mode_reg = mcm_r;
  assign stabilization_time_select = stabilization_time_select_r;
  assign stabilization_counter_status = st.status;
  assign cpu_on_subsystem_flag = cls_r;
  assign cpu_on_highspeed_flag = mcs_r;
  always_comb
  begin
    if (cls_r)
      cpu_src = SRC_SUBSYSTEM;
    else if (mcs_r)
      cpu_src = SRC_HIGHSPEED;
    else
      cpu_src = SRC_INTERNAL;
  end
  // Either the stop bit or STOP standby kills the internal oscillator
  assign internal_osc_run = !rcm_r[INT_STOP_BIT] && pm_r != PM_STOP;
  assign main_osc_run = !moc_r[MAIN_STOP_BIT] && pm_r != PM_STOP;
  assign halt_mode = pm_r == PM_HALT;
  assign stop_mode = pm_r == PM_STOP || pm_r == PM_WAKE;
  // Pins stay an input port until the subsystem crystal mode is chosen
  assign sub_port_in_mode = !osc_r[OSC_MODE_BIT];
  assign sub_port_data = pin_sync_r;
endmodule : cpu_clock_source_control
`default_nettype wire

// ### cpu_clock_source_control_bench.sv
// Self-checking bench for the CPU clock source controller
`default_nettype none
`define CHK(n, e, g) cmp(n, 8'(e), 8'(g))
module cpu_clock_source_control_bench;
  import clk_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, wr_bit = 1'b0;
  logic halt_exec = 1'b0, stop_exec = 1'b0, wake_req = 1'b0;
  logic [2:0] wr_sel = 3'h0, wr_bit_pos = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic sub_crystal_in_pin, sub_crystal_out_pin, cpu_on_subsystem_flag, cpu_on_highspeed_flag;
  logic internal_osc_run, main_osc_run, halt_mode, stop_mode, sub_port_in_mode;
  logic [7:0] osc_mode_select_reg, cpu_clock_ctrl_reg, internal_osc_mode_reg, main_osc_ctrl_reg;
  logic [7:0] main_clock_mode_reg, stabilization_counter_status;
  logic [STAB_SEL_W-1:0] stabilization_time_select;
  logic [1:0] cpu_src, sub_port_data;
  int err_count = 0, num_checks = 0;
  cpu_clock_source_control cpu_clock_source_control_i (.core_clk, .rst_b, .wr_en, .wr_bit, .wr_sel, .wr_bit_pos,
    .wr_data, .halt_exec, .stop_exec, .wake_req, .sub_crystal_in_pin, .sub_crystal_out_pin, .osc_mode_select_reg,
    .cpu_clock_ctrl_reg, .internal_osc_mode_reg, .main_osc_ctrl_reg, .main_clock_mode_reg,
    .stabilization_time_select, .stabilization_counter_status, .cpu_on_subsystem_flag, .cpu_on_highspeed_flag,
    .cpu_src, .internal_osc_run, .main_osc_run, .halt_mode, .stop_mode, .sub_port_in_mode, .sub_port_data);
  sub_pin_model sub_pin_model_i (.in_mode(sub_port_in_mode), .xin(sub_crystal_in_pin), .xout(sub_crystal_out_pin));
  initial forever #50 core_clk = ~core_clk;
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [2:0] s, input logic b, input logic [2:0] p, input logic [7:0] d);
    @(negedge core_clk);
    wr_en = 1'b1;
    wr_sel = s;
    wr_bit = b;
    wr_bit_pos = p;
    wr_data = d;
    cyc(1);
    wr_en = 1'b0;
  endtask
  // k: 0 wake, 1 halt, 2 stop
  task automatic pulse(input int k);
    @(negedge core_clk);
    {stop_exec, halt_exec, wake_req} = 3'h1 << k;
    cyc(1);
    {stop_exec, halt_exec, wake_req} = 3'h0;
  endtask
  task automatic standby(input int k, input logic osc);
    int n;
    pulse(k);
    `CHK("standby", k, {stop_mode, halt_mode});
    `CHK("int osc", osc, internal_osc_run);
    pulse(0);
    for (n = 0; n < 4000 && (halt_mode | stop_mode) !== 1'b0; n++)
      cyc(1);
    `CHK("woken", 0, halt_mode | stop_mode);
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    cyc(16);
    rst_b = 1'b1;
    cyc(3);
  endtask
  task automatic t_reset();
    `CHK("osc mode", OSC_MODE_RESET, osc_mode_select_reg);
    `CHK("main osc", MAIN_OSC_RESET, main_osc_ctrl_reg);
    `CHK("src", 0, {cpu_on_subsystem_flag, cpu_on_highspeed_flag, cpu_src});
    `CHK("port mode", 1, sub_port_in_mode);
    `CHK("port data", 3, sub_port_data);
    standby(1, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_mode();
    wr(SEL_OSC_MODE, 1'b1, 3'h6, 8'hff);
    `CHK("bit write", 8'h40, osc_mode_select_reg);
    `CHK("port mode", 0, sub_port_in_mode);
    wr(SEL_OSC_MODE, 1'b0, 3'h0, 8'h00);
    `CHK("byte write", 0, osc_mode_select_reg);
    $display("test mode done");
  endtask
  task automatic t_hs();
    wr(SEL_OSC_MODE, 1'b0, 3'h0, 8'hc0);
    wr(SEL_MAIN_OSC, 1'b0, 3'h0, 8'h00);
    wr(SEL_MAIN_CLK, 1'b0, 3'h0, 8'h05);
    cyc(2);
    `CHK("main run", 1, main_osc_run);
    `CHK("hs src", {1'b1, 2'h1}, {cpu_on_highspeed_flag, cpu_src});
    wr(SEL_MAIN_CLK, 1'b0, 3'h0, 8'h01);
    `CHK("hs once", 8'h05, main_clock_mode_reg);
    wr(SEL_INT_OSC, 1'b1, 3'h0, 8'hff);
    `CHK("int stop", 0, internal_osc_run);
    `CHK("int osc reg", 8'h01, internal_osc_mode_reg);
    standby(1, 1'b0);
    $display("test high speed done");
  endtask
  task automatic t_sub();
    wr(SEL_CPU_CTRL, 1'b1, 3'h4, 8'hff);
    cyc(2);
    `CHK("sub src", 2, cpu_src);
    `CHK("cpu ctrl", 8'h10, cpu_clock_ctrl_reg);
    standby(1, 1'b0);
    wr(SEL_CPU_CTRL, 1'b0, 3'h0, 8'h00);
    cyc(2);
    `CHK("back", 1, cpu_src);
    $display("test subsystem done");
  endtask
  task automatic t_stop();
    wr(SEL_STAB_SEL, 1'b0, 3'h0, 8'h02);
    `CHK("stab sel", 2, stabilization_time_select);
    standby(2, 1'b0);
    do_reset();
    `CHK("src", 0, cpu_src);
    wr(SEL_MAIN_CLK, 1'b0, 3'h0, 8'h04);
    `CHK("hs again", 8'h04, main_clock_mode_reg);
    standby(2, 1'b0);
    $display("test stop done");
  endtask
  task automatic t_xtal();
    int n;
    wr(SEL_CPU_CTRL, 1'b0, 3'h0, 8'h10);
    wr(SEL_STAB_SEL, 1'b0, 3'h0, 8'h00);
    wr(SEL_OSC_MODE, 1'b0, 3'h0, 8'h40);
    wr(SEL_MAIN_OSC, 1'b0, 3'h0, 8'h00);
    wr(SEL_MAIN_CLK, 1'b0, 3'h0, 8'h05);
    wr(SEL_CPU_CTRL, 1'b0, 3'h0, 8'h00);
    cyc(2);
    `CHK("xtal early", 0, cpu_on_highspeed_flag);
    for (n = 0; n < 4000 && stabilization_counter_status !== 8'hff; n++)
      cyc(1);
    `CHK("stab status", 8'hff, stabilization_counter_status);
    `CHK("stab wait", 1, n >= int'(STAB_BASE_CYCLES) - 16);
    cyc(2);
    `CHK("xtal src", {1'b1, 2'h1}, {cpu_on_highspeed_flag, cpu_src});
    pulse(2);
    `CHK("xtal stop", 1, stop_mode);
    pulse(0);
    cyc(4);
    `CHK("wake wait", 1, stop_mode);
    `CHK("main in wait", 1, main_osc_run);
    for (n = 0; n < 4000 && stop_mode !== 1'b0; n++)
      cyc(1);
    `CHK("xtal woken", 0, stop_mode);
    `CHK("wake span", 1, n >= int'(STAB_BASE_CYCLES) - 16);
    $display("test crystal done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #1000000;
    err_count++;
    close_out();
  end
  initial
  begin
    do_reset();
    t_reset();
    t_mode();
    t_hs();
    t_sub();
    t_stop();
    t_xtal();
    close_out();
  end
endmodule // cpu_clock_source_control_bench
`default_nettype wire

// ### stab_counter.sv
// Oscillation stabilization wait counter
`default_nettype none
module stab_counter
  import clk_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Controller side
  stab_if.counter st
);
  logic [STAB_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [STAB_CNT_W-1:0] target;
  logic [7:0] status_r, status_nxt;
  logic done_r, done_nxt;

  always_comb
  begin
    // Wait doubles with each select step
    target = STAB_CNT_W'(STAB_BASE_CYCLES << st.sel);
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    status_nxt = status_r;
    if (st.start)
    begin
      cnt_nxt = '0;
      done_nxt = 1'b0;
      status_nxt = 8'h00;
    end
    else if (!done_r)
    begin
      cnt_nxt = cnt_r + 1'b1;
      status_nxt = 8'(cnt_r >> (STAB_CNT_W - 8));
      if (cnt_r >= target)
      begin
        done_nxt = 1'b1;
        status_nxt = 8'hff;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= '0;
      done_r <= 1'b0;
      status_r <= 8'h00;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      status_r <= status_nxt;
    end
  end

  assign st.done = done_r;
  assign st.status = status_r;
endmodule : stab_counter
`default_nettype wire

// ### stab_if.sv
// Handshake between the controller and its stabilization counter
`default_nettype none
interface stab_if;
  import clk_ctrl_pkg::*;
  logic start;
  logic [STAB_SEL_W-1:0] sel;
  logic done;
  logic [7:0] status;
  modport ctrl (output start, output sel, input done, input status);
  modport counter (input start, input sel, output done, output status);
endinterface : stab_if
`default_nettype wire

// ### sub_pin_model.sv
// Model of what is wired to the subsystem crystal pins
`default_nettype none
module sub_pin_model (
  // Pin mode
  input wire logic in_mode,
  // Pin levels
  output logic xin,
  output logic xout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic osc = 1'b0;
  // Resonator swings outside port mode, so no stale level shows
  initial forever #730 osc = ~osc;
  assign xin = in_mode ? 1'b1 : osc;
  assign xout = in_mode ? 1'b1 : ~osc;
endmodule // sub_pin_model
`default_nettype wire
